// >>> rtl/crs_pkg.sv
// Package: constants and carriers for the CPU core register set
package crs_pkg;

    // ==================================================================
    // Widths
    localparam int DATA_W = 8;                          // Data-side register width
    localparam int PC_W   = 16;                         // Program counter width

    // ==================================================================
    // Register space
    localparam logic [8:0] FLAGS_ADDR   = 9'h0f7;       // Flags read address
    localparam logic [8:0] EXT_BASE     = 9'h100;       // First extended address

    // ==================================================================
    // Flag bit positions
    localparam int GIE_BIT   = 0;
    localparam int ZERO_BIT  = 1;
    localparam int CARRY_BIT = 2;
    localparam int SUPER_BIT = 3;
    localparam int BANK_BIT  = 4;

    // ==================================================================
    // Reset values
    localparam logic [7:0]  FLAGS_RST = 8'h02;
    localparam logic [7:0]  REG_RST   = 8'h00;
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  FLAGS_SW_MASK = 8'h17;      // Bits software may change
    localparam logic [7:0]  SP_ONE    = 8'h01;
    localparam logic [15:0] PC_ONE    = 16'h0001;

    // ==================================================================
    // Destination, flag, stack pointer and program counter operation selectors
    typedef enum logic [2:0] {
        CRS_DST_NONE = 3'h0,
        CRS_DST_A    = 3'h1,
        CRS_DST_X    = 3'h3,
        CRS_DST_SP   = 3'h2,
        CRS_DST_F    = 3'h6
    } crs_dst_e;

    typedef enum logic [1:0] {
        CRS_FOP_NONE = 2'h0,
        CRS_FOP_OR   = 2'h1,
        CRS_FOP_AND  = 2'h3,
        CRS_FOP_ALU  = 2'h2
    } crs_fop_e;

    typedef enum logic [2:0] {
        CRS_SP_HOLD = 3'h0,
        CRS_SP_INC  = 3'h1,
        CRS_SP_DEC  = 3'h3,
        CRS_SP_LOAD = 3'h2,
        CRS_SP_ADD  = 3'h6
    } crs_spop_e;

    typedef enum logic [1:0] {
        CRS_PC_HOLD = 2'h0,
        CRS_PC_INC  = 2'h1,
        CRS_PC_LOAD = 2'h3
    } crs_pcop_e;

    // Execution update from decoder and ALU
    typedef struct packed {
        crs_dst_e        dst;       // Which register takes wdata
        logic [7:0]      wdata;     // Result byte
        crs_fop_e        fop;       // Flag operation
        logic [7:0]      imm;       // Immediate for OR/AND to flags
        logic            alu_carry; // Carry out of ALU op
        logic            alu_zero;  // Zero result of ALU op
        crs_spop_e       spop;      // Stack pointer operation
        crs_pcop_e       pcop;      // Program counter operation
        logic [15:0]     pc_load;   // Jump or call target
    } crs_upd_s;

    // Register-space access request
    typedef struct packed {
        logic       rd;             // Read strobe
        logic [8:0] addr;           // Register-space address
    } crs_rs_req_s;

endpackage : crs_pkg

// >>> rtl/crs_flags.sv
// Flags register with software masking and core-only supervisor bit
`timescale 1ns/100ps
`default_nettype none
module crs_flags
    import crs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    // Update controls
    input  wire crs_fop_e   fop_i,
    input  wire logic [7:0] imm_i,
    input  wire logic       alu_carry_i,
    input  wire logic       alu_zero_i,
    input  wire logic       super_set_i,
    input  wire logic       super_clr_i,
    // Flags value
    output logic      [7:0] flags_o
);

    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] sw_val;

    // Next flags value
    always_comb begin
        sw_val    = flags_r;
        flags_nxt = flags_r;
        unique case (fop_i)
            CRS_FOP_OR:   sw_val = flags_r | imm_i;
            CRS_FOP_AND:  sw_val = flags_r & imm_i;
            default:      sw_val = flags_r;
        endcase
        // Supervisor and reserved bits keep their value on software ops
        flags_nxt = (sw_val & FLAGS_SW_MASK) | (flags_r & ~FLAGS_SW_MASK);
        if (fop_i == CRS_FOP_ALU) begin
            flags_nxt[CARRY_BIT] = alu_carry_i;
            flags_nxt[ZERO_BIT]  = alu_zero_i;
        end
        if (super_set_i) begin
            flags_nxt[SUPER_BIT] = 1'b1;
        end else if (super_clr_i) begin
            flags_nxt[SUPER_BIT] = 1'b0;
        end
    end

    // Register
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;

    property p_super_sw_blind;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (!super_set_i && !super_clr_i) |=> $stable(flags_r[SUPER_BIT]);
    endproperty
    a_super_sw_blind: assert property (p_super_sw_blind)
        else $error("supervisor bit changed without core request");

    property p_or_sets;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (fop_i == CRS_FOP_OR && imm_i[BANK_BIT]) |=> flags_r[BANK_BIT];
    endproperty
    a_or_sets: assert property (p_or_sets)
        else $error("OR to flags did not set bank bit");

    property p_rsv_zero;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        flags_r[7:5] == 3'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved flag bits nonzero");

endmodule : crs_flags
`default_nettype wire

// >>> rtl/crs_pc.sv
// Sixteen-bit program counter
`timescale 1ns/100ps
`default_nettype none
module crs_pc
    import crs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Control
    input  wire crs_pcop_e   pcop_i,
    input  wire logic [15:0] load_i,
    // Value
    output logic      [15:0] pc_o
);

    logic [15:0] pc_r;
    logic [15:0] pc_nxt;

    // Next program counter
    always_comb begin
        unique case (pcop_i)
            CRS_PC_INC:  pc_nxt = pc_r + PC_ONE;
            CRS_PC_LOAD: pc_nxt = load_i;
            default:     pc_nxt = pc_r;
        endcase
    end

    // Register; starts at program address zero
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            pc_r <= PC_RST;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    assign pc_o = pc_r;

    property p_pc_inc;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (pcop_i == CRS_PC_INC) |=> (pc_r == $past(pc_r) + PC_ONE);
    endproperty
    a_pc_inc: assert property (p_pc_inc)
        else $error("program counter did not step by one");

endmodule : crs_pc
`default_nettype wire

// >>> rtl/crs_core_regs.sv
// Core register set: accumulator, index, stack, program counter, flags
`timescale 1ns/100ps
`default_nettype none
module crs_core_regs
    import crs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Execution update from decoder and ALU
    input  wire crs_upd_s    upd_i,
    input  wire logic        super_enter_i,
    input  wire logic        super_leave_i,
    // Indexed address formation
    input  wire logic [7:0]  idx_operand_i,
    output logic      [7:0]  idx_addr_o,
    // Register-space access
    input  wire crs_rs_req_s rs_req_i,
    output logic      [7:0]  rs_rdata_o,
    output logic             rs_flags_hit_o,
    output logic             rs_ext_ok_o,
    output logic             rs_refused_o,
    // Interrupt gating
    input  wire logic        irq_pending_i,
    output logic             irq_take_o,
    // Register values
    output logic      [7:0]  acc_o,
    output logic      [7:0]  index_o,
    output logic      [7:0]  stack_top_o,
    output logic      [7:0]  program_counter_low_byte_o,
    output logic      [7:0]  program_counter_high_byte_o,
    output logic      [7:0]  flags_o,
    output logic             bank_select_bit_o
);

    // ==================================================================
    // State
    logic [7:0]  acc_r,     acc_nxt;
    logic [7:0]  index_r,   index_nxt;
    logic [7:0]  sp_r,      sp_nxt;
    logic [7:0]  idx_r,     idx_nxt;
    logic [7:0]  rdata_r,   rdata_nxt;
    logic        hit_r,     hit_nxt;
    logic        ext_r,     ext_nxt;
    logic        ref_r,     ref_nxt;
    logic        irq_r,     irq_nxt;
    logic [7:0]  flags_w;
    logic [15:0] pc_w;

    // ==================================================================
    // Submodules
    // Flags hold their own masking so software ops cannot reach bit 3
    crs_flags u_flags (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .fop_i       (upd_i.fop),
        .imm_i       (upd_i.imm),
        .alu_carry_i (upd_i.alu_carry),
        .alu_zero_i  (upd_i.alu_zero),
        .super_set_i (super_enter_i),
        .super_clr_i (super_leave_i),
        .flags_o     (flags_w)
    );

    crs_pc u_pc (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .pcop_i    (upd_i.pcop),
        .load_i    (upd_i.pc_load),
        .pc_o      (pc_w)
    );

    // ==================================================================
    // Accumulator and index next values
    always_comb begin
        acc_nxt   = acc_r;
        index_nxt = index_r;
        if (upd_i.dst == CRS_DST_A) begin
            acc_nxt = upd_i.wdata;
        end
        if (upd_i.dst == CRS_DST_X) begin
            index_nxt = upd_i.wdata;
        end
    end

    // Stack pointer next value; add uses the result byte as offset
    always_comb begin
        sp_nxt = sp_r;
        unique case (upd_i.spop)
            CRS_SP_INC:  sp_nxt = sp_r + SP_ONE;
            CRS_SP_DEC:  sp_nxt = sp_r - SP_ONE;
            CRS_SP_LOAD: sp_nxt = upd_i.wdata;
            CRS_SP_ADD:  sp_nxt = sp_r + upd_i.wdata;
            default:     sp_nxt = sp_r;
        endcase
        if (upd_i.dst == CRS_DST_SP && upd_i.spop == CRS_SP_HOLD) begin
            sp_nxt = upd_i.wdata;
        end
    end

    // Indexed address, registered; wraps within the 8-bit space
    always_comb begin
        idx_nxt = index_r + idx_operand_i;
    end

    // Register-space decode; only the flags answer, other core regs hidden
    always_comb begin
        hit_nxt   = rs_req_i.rd && (rs_req_i.addr == FLAGS_ADDR);
        rdata_nxt = hit_nxt ? flags_w : REG_RST;
        ext_nxt   = rs_req_i.rd && (rs_req_i.addr >= EXT_BASE)
                    && flags_w[BANK_BIT];
        ref_nxt   = rs_req_i.rd && (rs_req_i.addr >= EXT_BASE)
                    && !flags_w[BANK_BIT];
    end

    // Global interrupt gate
    always_comb begin
        irq_nxt = irq_pending_i && flags_w[GIE_BIT];
    end

    // ==================================================================
    // Registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            acc_r   <= REG_RST;
            index_r <= REG_RST;
            sp_r    <= REG_RST;
            idx_r   <= REG_RST;
            rdata_r <= REG_RST;
            hit_r   <= 1'b0;
            ext_r   <= 1'b0;
            ref_r   <= 1'b0;
            irq_r   <= 1'b0;
        end else begin
            acc_r   <= acc_nxt;
            index_r <= index_nxt;
            sp_r    <= sp_nxt;
            idx_r   <= idx_nxt;
            rdata_r <= rdata_nxt;
            hit_r   <= hit_nxt;
            ext_r   <= ext_nxt;
            ref_r   <= ref_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // Outputs; flags and PC come from flip-flops inside the submodules
    assign acc_o                       = acc_r;
    assign index_o                     = index_r;
    assign stack_top_o                 = sp_r;
    assign idx_addr_o                  = idx_r;
    assign rs_rdata_o                  = rdata_r;
    assign rs_flags_hit_o              = hit_r;
    assign rs_ext_ok_o                 = ext_r;
    assign rs_refused_o                = ref_r;
    assign irq_take_o                  = irq_r;
    assign flags_o                     = flags_w;
    assign bank_select_bit_o           = flags_w[BANK_BIT];
    assign program_counter_low_byte_o  = pc_w[7:0];
    assign program_counter_high_byte_o = pc_w[15:8];

    // ==================================================================
    // Checks
    property p_irq_gate;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        irq_take_o |-> $past(flags_w[GIE_BIT]) && $past(irq_pending_i);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt taken while globally disabled");

    property p_ext_gate;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rs_ext_ok_o |-> $past(flags_w[BANK_BIT]);
    endproperty
    a_ext_gate: assert property (p_ext_gate)
        else $error("extended space reached with bank bit clear");

    property p_flags_read;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (rs_req_i.rd && rs_req_i.addr == FLAGS_ADDR)
            |=> rs_flags_hit_o && rs_rdata_o == $past(flags_w);
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("flags read returned wrong value");

    property p_carry_alu;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.fop == CRS_FOP_ALU)
            |=> flags_w[CARRY_BIT] == $past(upd_i.alu_carry);
    endproperty
    a_carry_alu: assert property (p_carry_alu)
        else $error("carry flag not updated by ALU op");

    property p_zero_alu;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.fop == CRS_FOP_ALU)
            |=> flags_w[ZERO_BIT] == $past(upd_i.alu_zero);
    endproperty
    a_zero_alu: assert property (p_zero_alu)
        else $error("zero flag not updated by ALU op");

    property p_flags_quiet;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.fop == CRS_FOP_NONE && !super_enter_i && !super_leave_i)
            |=> $stable(flags_w);
    endproperty
    a_flags_quiet: assert property (p_flags_quiet)
        else $error("flags changed without flag operation");

    property p_sp_push;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.spop == CRS_SP_INC) |=> stack_top_o == $past(sp_r) + SP_ONE;
    endproperty
    a_sp_push: assert property (p_sp_push)
        else $error("stack pointer did not step up");

    property p_idx_addr;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        1'b1 |=> idx_addr_o == 8'($past(index_r) + $past(idx_operand_i));
    endproperty
    a_idx_addr: assert property (p_idx_addr)
        else $error("indexed address wrong");

    property p_reset_vals;
        @(posedge clk_sys_i)
        !rst_b_i |=> acc_o == REG_RST && pc_w == PC_RST && flags_w == FLAGS_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    // Extended read while bank 0 is selected; must be turned away
    sequence s_ext_bank0;
        rs_req_i.rd && (rs_req_i.addr >= EXT_BASE) && !flags_w[BANK_BIT];
    endsequence

    property p_ext_refused;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        s_ext_bank0 |=> rs_refused_o && !rs_ext_ok_o;
    endproperty
    a_ext_refused: assert property (p_ext_refused)
        else $error("extended read with bank clear not refused");

    property p_hidden_regs;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (rs_req_i.rd && rs_req_i.addr != FLAGS_ADDR)
            |=> !rs_flags_hit_o && rs_rdata_o == REG_RST;
    endproperty
    a_hidden_regs: assert property (p_hidden_regs)
        else $error("core register visible in register space");

    property p_acc_write;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.dst == CRS_DST_A) |=> acc_o == $past(upd_i.wdata);
    endproperty
    a_acc_write: assert property (p_acc_write)
        else $error("accumulator did not take result byte");

    property p_pc_load;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.pcop == CRS_PC_LOAD)
            |=> {program_counter_high_byte_o, program_counter_low_byte_o} == $past(upd_i.pc_load);
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("program counter did not take jump target");

    property p_bank_clear;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.fop == CRS_FOP_AND && !upd_i.imm[BANK_BIT]) |=> !bank_select_bit_o;
    endproperty
    a_bank_clear: assert property (p_bank_clear)
        else $error("AND to flags did not clear bank bit");

    property p_super_enter;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        super_enter_i |=> flags_w[SUPER_BIT];
    endproperty
    a_super_enter: assert property (p_super_enter)
        else $error("supervisor bit not set on entry");

    property p_irq_open;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (irq_pending_i && flags_w[GIE_BIT]) |=> irq_take_o;
    endproperty
    a_irq_open: assert property (p_irq_open)
        else $error("enabled interrupt not taken");

    property p_sp_pop;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.spop == CRS_SP_DEC) |=> stack_top_o == 8'($past(sp_r) - SP_ONE);
    endproperty
    a_sp_pop: assert property (p_sp_pop)
        else $error("stack pointer did not step down");

    property p_sp_add;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (upd_i.spop == CRS_SP_ADD)
            |=> stack_top_o == 8'($past(sp_r) + $past(upd_i.wdata));
    endproperty
    a_sp_add: assert property (p_sp_add)
        else $error("stack pointer add wrong");

endmodule : crs_core_regs
`default_nettype wire

// >>> tb/crs_dec_model.sv
// Decoder and ALU stand-in that issues updates to the core registers
`timescale 1ns/100ps
`default_nettype none
module crs_dec_model
    import crs_pkg::*;
(
    // Clock
    input  wire logic       clk_sys_i,
    // Current accumulator, operand of the adder
    input  wire logic [7:0] acc_i,
    // Update word to the core registers
    output var  crs_upd_s   upd_o
);
    // ==================================================================
    // Idle word: no write, no flag change, counters held
    initial upd_o = '0;

    // One instruction held for exactly one taking edge, then idle again
    task automatic issue(input crs_upd_s u);
        @(posedge clk_sys_i);
        #1;
        upd_o = u;
        @(posedge clk_sys_i);
        #1;
        upd_o = '0;
    endtask : issue

    // Software flag set or clear with an immediate mask
    task automatic flag_op(input crs_fop_e op, input logic [7:0] imm);
        crs_upd_s u;
        u     = '0;
        u.fop = op;
        u.imm = imm;
        issue(u);
    endtask : flag_op

    // Add to accumulator; carry and zero come from this adder
    task automatic add_acc(input logic [7:0] b);
        crs_upd_s   u;
        logic [8:0] s;
        s           = {1'b0, acc_i} + {1'b0, b};
        u           = '0;
        u.dst       = CRS_DST_A;
        u.wdata     = s[7:0];
        u.fop       = CRS_FOP_ALU;
        u.alu_carry = s[8];
        u.alu_zero  = (s[7:0] == 8'h00);
        issue(u);
    endtask : add_acc
endmodule : crs_dec_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench for the core register set
`timescale 1ns/100ps
`default_nettype none
module tb;
    import crs_pkg::*;
    // ==================================================================
    // Signals
    logic        clk_sys_i;
    logic        rst_b_i;
    crs_upd_s    upd;
    logic        super_enter;
    logic        super_leave;
    logic [7:0]  idx_operand;
    logic [7:0]  idx_addr;
    crs_rs_req_s rs_req;
    logic [7:0]  rs_rdata;
    logic        rs_hit;
    logic        rs_ext_ok;
    logic        rs_refused;
    logic        irq_pending;
    logic        irq_take;
    logic [7:0]  acc, index, sp, pcl, pch, flags;
    logic        bank;
    int          err_total;
    int          checked;
    crs_upd_s    u;
    logic [7:0]  f_exp, a_exp;
    logic [8:0]  s;
    crs_spop_e   sp_op [6] = '{CRS_SP_LOAD, CRS_SP_INC, CRS_SP_DEC, CRS_SP_DEC,
                               CRS_SP_ADD, CRS_SP_HOLD};
    logic [7:0]  sp_wd [6] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h90, 8'h33};
    logic [7:0]  sp_ex [6] = '{8'h80, 8'h81, 8'h80, 8'h7f, 8'h0f, 8'h33};
    logic [7:0]  add_b [3] = '{8'hff, 8'h01, 8'h05};

    // ==================================================================
    // Instances
    crs_core_regs dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .upd_i(upd),
        .super_enter_i(super_enter), .super_leave_i(super_leave),
        .idx_operand_i(idx_operand), .idx_addr_o(idx_addr),
        .rs_req_i(rs_req), .rs_rdata_o(rs_rdata), .rs_flags_hit_o(rs_hit),
        .rs_ext_ok_o(rs_ext_ok), .rs_refused_o(rs_refused),
        .irq_pending_i(irq_pending), .irq_take_o(irq_take),
        .acc_o(acc), .index_o(index), .stack_top_o(sp),
        .program_counter_low_byte_o(pcl), .program_counter_high_byte_o(pch),
        .flags_o(flags), .bank_select_bit_o(bank));
    crs_dec_model dec (.clk_sys_i(clk_sys_i), .acc_i(acc), .upd_o(upd));

    // ==================================================================
    // Clock, 5 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // ==================================================================
    // Compare and verdict
    task automatic check(input string name, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Register-space read; strobe lives one taking edge
    task automatic rs_read(input logic [8:0] addr);
        @(posedge clk_sys_i);
        #1;
        rs_req = '{rd: 1'b1, addr: addr};
        @(posedge clk_sys_i);
        #1;
        rs_req = '{rd: 1'b0, addr: addr};
    endtask : rs_read

    // Core entering or leaving supervisor code
    task automatic super_pulse(input logic en, input logic lv);
        @(posedge clk_sys_i);
        #1;
        super_enter = en;
        super_leave = lv;
        @(posedge clk_sys_i);
        #1;
        super_enter = 1'b0;
        super_leave = 1'b0;
    endtask : super_pulse

    // Level input held over one taking edge, then the answer is looked at
    task automatic set_irq(input logic p);
        irq_pending = p;
        @(posedge clk_sys_i);
        #1;
    endtask : set_irq

    // Watchdog: whole sequence needs well under 200 cycles
    initial begin
        #20000;
        err_total++;
        complete_run();
    end

    // ==================================================================
    // Main sequence
    initial begin
        err_total = 0;
        checked = 0;
        rst_b_i = 1'b0;
        super_enter = 1'b0;
        super_leave = 1'b0;
        idx_operand = 8'h00;
        rs_req = '0;
        irq_pending = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        rst_b_i = 1'b1;
        check("flags", flags, 16'h0002);
        check("regs", {acc, index}, 16'h0000);
        check("pc", {pch, pcl}, 16'h0000);
        check("sp0", {8'h00, sp}, 16'h0000);
        rs_read(FLAGS_ADDR);
        check("rd_flags", {7'h00, rs_hit, rs_rdata}, 16'h0102);
        rs_read(9'h0f6);
        check("rd_other", {7'h00, rs_hit, rs_rdata}, 16'h0000);
        rs_read(EXT_BASE);
        check("ext_bank0", {rs_ext_ok, rs_refused}, 16'h0001);
        rs_read(9'h0ff);
        check("low_top", {rs_ext_ok, rs_refused}, 16'h0000);
        // Set every bit: reserved and supervisor must stay low
        dec.flag_op(CRS_FOP_OR, 8'hff);
        check("or_all", flags, 16'h0017);
        check("bank", bank, 16'h0001);
        rs_read(9'h1e0);
        check("ext_bank1", {rs_ext_ok, rs_refused}, 16'h0002);
        set_irq(1'b1);
        check("irq_on", irq_take, 16'h0001);
        dec.flag_op(CRS_FOP_AND, 8'hfe);
        check("and_gie", flags, 16'h0016);
        set_irq(1'b1);
        check("irq_off", irq_take, 16'h0000);
        super_pulse(1'b1, 1'b0);
        check("super_in", flags, 16'h001e);
        dec.flag_op(CRS_FOP_AND, 8'h00);
        check("and_none", flags, 16'h0008);
        super_pulse(1'b1, 1'b1);
        check("super_both", flags, 16'h0008);
        super_pulse(1'b0, 1'b1);
        check("super_out", flags, 16'h0000);
        // Adder results drive carry and zero
        f_exp = 8'h00;
        a_exp = 8'h00;
        foreach (add_b[i]) begin
            s = {1'b0, a_exp} + {1'b0, add_b[i]};
            a_exp = s[7:0];
            f_exp = {5'h00, s[8], s[7:0] == 8'h00, 1'b0};
            dec.add_acc(add_b[i]);
            check("acc", acc, {8'h00, a_exp});
            check("alu_flags", flags, {8'h00, f_exp});
        end
        // Plain move into index leaves flags alone
        u = '0;
        u.dst = CRS_DST_X;
        u.wdata = 8'hf0;
        dec.issue(u);
        check("mov_flags", flags, {8'h00, f_exp});
        idx_operand = 8'h20;
        set_irq(1'b0);
        check("idx_addr", {index, idx_addr}, 16'hf010);
        // Stack pointer operations, wrap on add
        foreach (sp_op[i]) begin
            u = '0;
            u.dst = (sp_op[i] == CRS_SP_HOLD) ? CRS_DST_SP : CRS_DST_NONE;
            u.spop = sp_op[i];
            u.wdata = sp_wd[i];
            dec.issue(u);
            check("sp", sp, {8'h00, sp_ex[i]});
        end
        // Program counter load and wrap through the top of the space
        u = '0;
        u.pcop = CRS_PC_LOAD;
        u.pc_load = 16'hfffe;
        dec.issue(u);
        check("pc_load", {pch, pcl}, 16'hfffe);
        u = '0;
        u.pcop = CRS_PC_INC;
        dec.issue(u);
        check("pc_inc", {pch, pcl}, 16'hffff);
        dec.issue(u);
        check("pc_wrap", {pch, pcl}, 16'h0000);
        complete_run();
    end
endmodule : tb
`default_nettype wire
